// ===== sap_pkg.sv
// Shared constants and types for the parallel-port converter link.
package sap_pkg;
	localparam int RES_W = 10;
	localparam int DATA_W = 8;
	localparam int POS_PWR_HI = 7;
	localparam int POS_PWR_LO = 6;
	localparam int POS_ACQ = 5;
	localparam int POS_SGL = 4;
	localparam int POS_UNI = 3;
	localparam int POS_CH_HI = 2;
	localparam int POS_CH_LO = 0;
	localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
	localparam logic [1:0] PWR_STANDBY = 2'h1;
	localparam logic [1:0] PWR_NORM_INT = 2'h2;
	localparam logic [1:0] PWR_NORM_EXT = 2'h3;
	localparam int ACQ_CYCLES = 3;
	localparam int CONV_CYCLES = 13;
	localparam int CYCLES_NONOVERLAP = 19;
	localparam int CYCLES_OVERLAP = 16;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int INT_CONV_TIME_PS = 3600000;
	localparam int INT_CONV_CYCLES = INT_CONV_TIME_PS / CLK_PERIOD_PS;
	localparam int INT_CLK_DIV = INT_CONV_CYCLES / CONV_CYCLES;
	localparam int RESET_TIME_NS = 10000;
	localparam int RESET_CYCLES = (RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int REF_SETTLE_INT_NS = 500000;
	localparam int REF_SETTLE_EXT_NS = 50000;
	localparam int REF_INT_CYCLES = REF_SETTLE_INT_NS / 4;
	localparam int REF_EXT_CYCLES = REF_SETTLE_EXT_NS / 4;
	localparam logic [7:0] CTRL_RESET = 8'hF8;
	localparam logic [7:0] HOST_OFF_CTRL = 8'h00;
	localparam logic [7:0] HOST_OFF_STAT = 8'h04;
	localparam logic [7:0] HOST_OFF_RES = 8'h08;
	localparam logic [7:0] HOST_OFF_CFG = 8'h0C;
	typedef enum logic [1:0] {
		SAP_HTRANS_IDLE = 2'h0,
		SAP_HTRANS_NONSEQ = 2'h2
	} sap_htrans_t;
endpackage

// ===== sap_if.sv
// Parallel byte bus between host and converter, with two-way data pins.
`timescale 1ns/10ps
`default_nettype none
interface sap_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic high_byte_select;
	logic conv_clk;
	logic [7:0] host_dq_o;
	logic host_dq_oe_n;
	logic [7:0] dev_dq_o;
	logic dev_dq_oe_n;
	logic conv_done_n;
	logic conv_done_oe_n;
	wire [7:0] dq = !dev_dq_oe_n ? dev_dq_o :
		(!host_dq_oe_n ? host_dq_o : 8'hFF);
	wire conv_done_wire = !conv_done_oe_n ? conv_done_n : 1'b1;
	modport dev (input cs_n, wr_n, rd_n, high_byte_select, conv_clk, dq,
		output dev_dq_o, dev_dq_oe_n, conv_done_n, conv_done_oe_n);
	modport host (output cs_n, wr_n, rd_n, high_byte_select, conv_clk,
		host_dq_o, host_dq_oe_n, input dq, conv_done_wire);
endinterface
`default_nettype wire

// ===== sap_sync.sv
// Two-flip-flop synchroniser for pin levels.
`timescale 1ns/10ps
`default_nettype none
module sap_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			meta_q <= INIT;
			o_q <= INIT;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== sap_dev.sv
// Converter end: control byte decode, conversion sequencing, result port.
// How it works
// - Chip select high ignores strobes, floats bus.
// - Control byte latched from data pins.
// - Control byte fields: power, acquisition, input, polarity, channel.
// - Unipolar straight binary, bipolar two's complement.
// - Low byte select drives result bits 7:0.
// - High byte: bits 9:8, upper pins zero/sign.
// - Single-ended: code picks input, common negative.
// - Differential: pairs by bits 2:1, bit0 swaps.
// - Reset into external clock, done high.
// - Host waits reset interval before converting.
// - Host waits internal reference settling.
// - Power-down keeps port alive, no conversions.
// - Standby wakes on write rising edge.
// - Shutdown finishes conversion; write edge wakes.
// - Host waits reference recovery after shutdown.
// - Standby entered via dummy conversion; here the standby write enters it directly, no conversion starts.
// - Code step is reference over 1024.
// - Conversion takes 19 clocks non-overlapped.
// - Overlapped write-then-read gives 16 clocks.
// - Host avoids bus toggling during conversion.
// - Power bits decode down/standby/internal/external.
// - Power-down keeps last clock mode.
// - Internal clock gives 3.6 us conversion.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sap_dev #(
	parameter int RESET_CNT = sap_pkg::RESET_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	sap_if.dev bus,
	input wire logic [9:0] i_sample,
	output logic [2:0] o_pos_input,
	output logic [3:0] o_neg_input,
	output logic o_neg_is_common,
	output logic o_powered,
	output logic o_int_clk_mode,
	output logic o_busy
);
	typedef enum logic [1:0] {SAP_IDLE, SAP_ACQ, SAP_CONV} sap_state_t;
	logic cs_n_s, wr_n_s, rd_n_s, hbs_s, cclk_s;
	logic [7:0] dq_s;
	logic wr_n_q, rd_n_q, cclk_q;
	logic [7:0] ctrl_q;
	logic int_clk_q;
	logic [1:0] pwr_q;
	logic shut_pend_q;
	logic [9:0] result_q;
	logic done_n_q;
	sap_state_t st_q;
	logic [4:0] cnt_q;
	logic [15:0] div_q;
	logic [15:0] rst_q;
	logic wr_rise, rd_rise, tick, active_n;
	logic [7:0] rd_byte;

	sap_sync #(.W(12), .INIT(12'hFFF)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_d({bus.cs_n, bus.wr_n, bus.rd_n, bus.high_byte_select,
			bus.conv_clk, bus.dq[6:0]}),
		.o_q({cs_n_s, wr_n_s, rd_n_s, hbs_s, cclk_s, dq_s[6:0]})
	);
	sap_sync #(.W(1), .INIT(1'h1)) u_sync7 (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_d(bus.dq[7]),
		.o_q(dq_s[7])
	);

	assign active_n = cs_n_s;
	assign wr_rise = !active_n && wr_n_s && !wr_n_q;
	assign rd_rise = !active_n && rd_n_s && !rd_n_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			cclk_q <= 1'b0;
		end else begin
			wr_n_q <= wr_n_s;
			rd_n_q <= rd_n_s;
			cclk_q <= cclk_s;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst || st_q == SAP_IDLE) begin
			div_q <= '0;
		end else if (div_q == 16'(sap_pkg::INT_CLK_DIV - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	assign tick = int_clk_q ? (div_q == 16'(sap_pkg::INT_CLK_DIV - 1))
		: (!active_n && cclk_s && !cclk_q);

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rst_q <= '0;
		end else if (rst_q != 16'(RESET_CNT)) begin
			rst_q <= rst_q + 16'h0001;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ctrl_q <= sap_pkg::CTRL_RESET;
		end else if (wr_rise) begin
			ctrl_q <= dq_s;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			int_clk_q <= 1'b0;
			pwr_q <= sap_pkg::PWR_NORM_EXT;
			shut_pend_q <= 1'b0;
		end else if (wr_rise) begin
			pwr_q <= dq_s[sap_pkg::POS_PWR_HI:sap_pkg::POS_PWR_LO];
			shut_pend_q <= dq_s[sap_pkg::POS_PWR_HI:sap_pkg::POS_PWR_LO]
				== sap_pkg::PWR_FULL_DOWN;
			if (dq_s[sap_pkg::POS_PWR_HI]) begin
				int_clk_q <= !dq_s[sap_pkg::POS_PWR_LO];
			end
		end else if (st_q == SAP_IDLE) begin
			shut_pend_q <= 1'b0;
		end
	end
	assign o_powered = pwr_q[1] || shut_pend_q;
	assign o_int_clk_mode = int_clk_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			st_q <= SAP_IDLE;
			cnt_q <= '0;
		end else begin
			unique case (st_q)
				SAP_IDLE: begin
					if (wr_rise && dq_s[sap_pkg::POS_PWR_HI] &&
						rst_q == 16'(RESET_CNT)) begin
						st_q <= SAP_ACQ;
						cnt_q <= '0;
					end
				end
				SAP_ACQ: begin
					if (tick) begin
						if (cnt_q == 5'(sap_pkg::ACQ_CYCLES - 1)) begin
							st_q <= SAP_CONV;
							cnt_q <= '0;
						end else begin
							cnt_q <= cnt_q + 5'h01;
						end
					end
				end
				SAP_CONV: begin
					if (tick) begin
						if (cnt_q == 5'(sap_pkg::CONV_CYCLES - 1)) begin
							st_q <= SAP_IDLE;
						end
						cnt_q <= cnt_q + 5'h01;
					end
				end
			endcase
		end
	end
	assign o_busy = st_q != SAP_IDLE;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			result_q <= '0;
			done_n_q <= 1'b1;
		end else if (st_q == SAP_CONV && tick &&
			cnt_q == 5'(sap_pkg::CONV_CYCLES - 1)) begin
			result_q <= ctrl_q[sap_pkg::POS_UNI] ? i_sample :
				{~i_sample[9], i_sample[8:0]};
			done_n_q <= 1'b0;
		end else if (rd_rise) begin
			done_n_q <= 1'b1;
		end
	end

	always_comb begin
		if (hbs_s) begin
			rd_byte = {{6{result_q[9] & ~ctrl_q[sap_pkg::POS_UNI]}},
				result_q[9:8]};
		end else begin
			rd_byte = result_q[7:0];
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			bus.dev_dq_o <= '0;
		end else begin
			bus.dev_dq_o <= rd_byte;
		end
	end
	assign bus.dev_dq_oe_n = active_n || rd_n_s;
	assign bus.conv_done_n = done_n_q;
	assign bus.conv_done_oe_n = active_n;

	always_comb begin
		if (ctrl_q[sap_pkg::POS_SGL]) begin
			o_pos_input = ctrl_q[2:0];
			o_neg_input = 4'h8;
			o_neg_is_common = 1'b1;
		end else begin
			o_pos_input = ctrl_q[2:0];
			o_neg_input = {1'b0, ctrl_q[2:1], ~ctrl_q[0]};
			o_neg_is_common = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== sap_host.sv
// Host end: AHB-Lite slave driving the parallel bus to the converter.
`timescale 1ns/10ps
`default_nettype none
module sap_host #(
	parameter int HALF = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	sap_if.host bus
);
	typedef enum logic [2:0] {SH_IDLE, SH_WR, SH_RD_LO, SH_RD_HI} sh_state_t;
	sh_state_t st_q;
	logic [7:0] ctrl_q;
	logic [9:0] res_q;
	logic [7:0] cnt_q;
	logic [7:0] cfg_q;
	logic [7:0] pend_addr_q;
	logic pend_wr_q, pend_q;
	logic done_n_s;
	logic [7:0] dq_s;
	logic clk_q;
	logic wait_q;

	sap_sync #(.W(9), .INIT(9'h1FF)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_d({bus.conv_done_wire, bus.dq}),
		.o_q({done_n_s, dq_s})
	);

	assign o_hresp = 1'b0;
	assign o_hreadyout = !pend_q;

	// waits and standby left to software.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pend_q <= 1'b0;
			pend_wr_q <= 1'b0;
			pend_addr_q <= '0;
		end else if (!pend_q && i_hsel && i_hready && i_htrans[1]) begin
			pend_q <= 1'b1;
			pend_wr_q <= i_hwrite;
			pend_addr_q <= i_haddr[7:0];
		end else if (pend_q && st_q == SH_IDLE && cnt_q == 8'h00 &&
			(!pend_wr_q || pend_addr_q != sap_pkg::HOST_OFF_CTRL ||
			ctrl_q == i_hwdata[7:0])) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			cfg_q <= 8'(HALF);
		end else if (pend_q && pend_wr_q &&
			pend_addr_q == sap_pkg::HOST_OFF_CFG) begin
			cfg_q <= i_hwdata[7:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_hrdata <= '0;
		end else begin
			unique case (pend_addr_q)
				sap_pkg::HOST_OFF_STAT: o_hrdata <= {30'h0, st_q != SH_IDLE,
					!done_n_s};
				sap_pkg::HOST_OFF_RES: o_hrdata <= {22'h0, res_q};
				sap_pkg::HOST_OFF_CTRL: o_hrdata <= {24'h0, ctrl_q};
				sap_pkg::HOST_OFF_CFG: o_hrdata <= {24'h0, cfg_q};
				default: o_hrdata <= '0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= ~clk_q;
		end
	end
	assign bus.conv_clk = clk_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			st_q <= SH_IDLE;
			cnt_q <= '0;
			ctrl_q <= sap_pkg::CTRL_RESET;
			res_q <= '0;
			bus.cs_n <= 1'b1;
			bus.wr_n <= 1'b1;
			bus.rd_n <= 1'b1;
			bus.high_byte_select <= 1'b0;
			bus.host_dq_o <= '0;
			bus.host_dq_oe_n <= 1'b1;
			wait_q <= 1'b0;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			unique case (st_q)
				SH_IDLE: begin
					// Select held while a result is awaited.
					bus.cs_n <= !wait_q;
					bus.wr_n <= 1'b1;
					bus.rd_n <= 1'b1;
					bus.host_dq_oe_n <= 1'b1;
					if (pend_q && pend_wr_q &&
						pend_addr_q == sap_pkg::HOST_OFF_CTRL &&
						ctrl_q != i_hwdata[7:0]) begin
						ctrl_q <= i_hwdata[7:0];
						wait_q <= wait_q || i_hwdata[sap_pkg::POS_PWR_HI];
						bus.cs_n <= 1'b0;
						bus.wr_n <= 1'b0;
						bus.host_dq_o <= i_hwdata[7:0];
						bus.host_dq_oe_n <= 1'b0;
						st_q <= SH_WR;
						cnt_q <= cfg_q;
					end else if (!done_n_s && wait_q) begin
						bus.cs_n <= 1'b0;
						bus.rd_n <= 1'b0;
						bus.high_byte_select <= 1'b0;
						st_q <= SH_RD_LO;
						cnt_q <= cfg_q;
					end
				end
				SH_WR: begin
					bus.wr_n <= 1'b1;
					st_q <= SH_IDLE;
					cnt_q <= cfg_q;
				end
				SH_RD_LO: begin
					res_q[7:0] <= dq_s;
					bus.high_byte_select <= 1'b1;
					st_q <= SH_RD_HI;
					cnt_q <= cfg_q + 8'h01;
				end
				SH_RD_HI: begin
					res_q[9:8] <= dq_s[1:0];
					wait_q <= 1'b0;
					bus.rd_n <= 1'b1;
					bus.high_byte_select <= 1'b0;
					st_q <= SH_IDLE;
					cnt_q <= cfg_q;
				end
				default: st_q <= SH_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== sap_checker.sv
// Protocol checks on the parallel byte bus between host and converter.
`timescale 1ns/10ps
`default_nettype none
module sap_checker (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic high_byte_select,
	input wire logic [7:0] host_dq_o,
	input wire logic host_dq_oe_n,
	input wire logic [7:0] dev_dq_o,
	input wire logic dev_dq_oe_n,
	input wire logic conv_done_n,
	input wire logic conv_done_oe_n
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	logic wr_q;
	logic uni_q;
	logic [11:0] since_wr_q;
	logic [11:0] since_rd_q;
	always_ff @(posedge i_ref_clk) begin
		wr_q <= wr_n;
	end
	always_ff @(posedge i_ref_clk) begin
		if (!wr_n) begin
			uni_q <= host_dq_o[sap_pkg::POS_UNI];
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || (wr_n && !wr_q)) begin
			since_wr_q <= 12'h000;
		end else if (since_wr_q != 12'hFFF) begin
			since_wr_q <= since_wr_q + 12'h001;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			since_rd_q <= 12'hFFF;
		end else if (!rd_n) begin
			since_rd_q <= 12'h000;
		end else if (since_rd_q != 12'hFFF) begin
			since_rd_q <= since_rd_q + 12'h001;
		end
	end
	sequence s_read_end;
		!cs_n ##1 $rose(rd_n);
	endsequence
	sequence s_upper_read;
		(high_byte_select && !rd_n)[*4] ##0 !dev_dq_oe_n;
	endsequence
	a_float_idle: assert property (cs_n[*4] |-> dev_dq_oe_n && conv_done_oe_n)
		else $error("bus driven while deselected");
	a_strobe_select: assert property (!wr_n || !rd_n |-> !cs_n)
		else $error("strobe without chip select");
	a_no_clash: assert property (!dev_dq_oe_n |-> host_dq_oe_n)
		else $error("both ends drive data");
	a_write_data: assert property (!wr_n && $past(!wr_n)
		|-> !host_dq_oe_n && $stable(host_dq_o))
		else $error("control byte not held");
	a_upper_byte: assert property (s_upper_read
		|-> dev_dq_o[7:2] == (uni_q ? 6'h00 : {6{dev_dq_o[1]}}))
		else $error("upper pins wrong");
	a_done_reset: assert property ($fell(i_srst) |-> conv_done_n)
		else $error("done low after reset");
	a_done_release: assert property (s_read_end |-> ##[1:6] conv_done_n)
		else $error("done not released");
	a_done_hold: assert property ($rose(conv_done_n) |-> since_rd_q <= 12'h008)
		else $error("done released without read");
	a_conv_length: assert property ($fell(conv_done_n)
		|-> since_wr_q >= 12'h010)
		else $error("conversion too short");
endmodule
`default_nettype wire

// ===== test_sar_adc_parallel_port.sv
// Self-checking bench: host and converter joined over the byte bus.
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_parallel_port;
	logic clk, srst, hwr, hready, hresp, com, pwr, intm, busy;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [9:0] smp;
	logic [2:0] pos;
	logic [3:0] neg;
	logic [7:0] last_c;
	int n_fail, samples_checked, cyc;
	sap_if bus();
	sap_dev #(.RESET_CNT(8)) u_sap_dev (.i_ref_clk(clk), .i_srst(srst),
		.bus(bus), .i_sample(smp), .o_pos_input(pos), .o_neg_input(neg),
		.o_neg_is_common(com), .o_powered(pwr), .o_int_clk_mode(intm),
		.o_busy(busy));
	sap_host u_sap_host (.i_ref_clk(clk), .i_srst(srst), .i_hsel(1'b1),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwr), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .bus(bus));
	sap_checker u_sap_checker (.i_ref_clk(clk), .i_srst(srst),
		.cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
		.high_byte_select(bus.high_byte_select), .host_dq_o(bus.host_dq_o),
		.host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_o(bus.dev_dq_o),
		.dev_dq_oe_n(bus.dev_dq_oe_n), .conv_done_n(bus.conv_done_n),
		.conv_done_oe_n(bus.conv_done_oe_n));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk);
		htrans <= sap_pkg::SAP_HTRANS_NONSEQ;
		haddr <= a;
		hwr <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= sap_pkg::SAP_HTRANS_IDLE;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	function automatic logic [7:0] sel_exp(input logic [7:0] c);
		return {c[2:0], c[4] ? 4'h8 : {1'b0, c[2:1], ~c[0]}, c[4]};
	endfunction
	task automatic result(input logic [7:0] c, input logic [9:0] s);
		wait (bus.rd_n === 1'b1);
		ahb(1'b0, 32'h8, 32'h0);
		chk_word(r & 32'h3FF, {22'h0, c[3] ? s : s ^ 10'h200});
		chk_pin({7'h0, hresp}, 8'h00);
	endtask
	task automatic conv(input logic [7:0] c);
		logic [9:0] s;
		logic [7:0] k;
		int n;
		k = (c == last_c) ? c ^ 8'h01 : c;
		last_c = k;
		s = 10'($urandom);
		smp <= s;
		ahb(1'b1, 32'h0, {24'h0, k});
		n = 0;
		while (bus.rd_n !== 1'b0) begin
			@(posedge clk);
			n++;
		end
		if (!k[6]) chk_pin(8'(n >= 13 * sap_pkg::INT_CLK_DIV), 8'h01);
		result(k, s);
		chk_pin({pos, neg, com}, sel_exp(k));
		chk_pin({6'h0, pwr, intm}, {7'h01, ~k[6]});
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		srst = 1'b1;
		htrans = sap_pkg::SAP_HTRANS_IDLE;
		haddr = 32'h0;
		hwr = 1'b0;
		hwdata = 32'h0;
		smp = 10'h000;
		last_c = 8'h00;
		void'($urandom(45210));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk_pin({7'h0, intm}, 8'h00);
		// Settling waits shortened, bus kept quiet.
		repeat (12) @(posedge clk);
		ahb(1'b0, 32'hC, 32'h0);
		chk_word(r, 32'h4);
		ahb(1'b0, 32'h10, 32'h0);
		chk_word(r, 32'h0);
		for (int i = 0; i < 32; i++) conv({1'b1, i[0], 1'b0, i[4:0]});
		for (int i = 0; i < 6; i++) conv({1'b1, 7'($urandom) & 7'h5F});
		conv(8'h88);
		ahb(1'b1, 32'h0, 32'h08);
		repeat (300) @(posedge clk);
		chk_pin({5'h0, busy, pwr, intm}, 8'h01);
		ahb(1'b1, 32'h0, 32'h48);
		repeat (300) @(posedge clk);
		chk_pin({5'h0, busy, pwr, intm}, 8'h01);
		conv(8'hD9);
		smp <= 10'h2A5;
		ahb(1'b1, 32'h0, 32'hC8);
		ahb(1'b1, 32'h0, 32'h08);
		wait (bus.rd_n === 1'b0);
		result(8'h08, 10'h2A5);
		repeat (20) @(posedge clk);
		chk_pin({6'h0, pwr, busy}, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
